//--- common/afe_tdm_params.svh
`ifndef AFE_TDM_PARAMS_SVH
`define AFE_TDM_PARAMS_SVH

// ======================================================
// Serial frame geometry
`define FRAME_BITS      192
`define SLOT_W          21
`define LAST_SLOT       4'h8
`define DATA_SLOT_LAST  5'h14
`define SYNC_SLOT_LAST  5'h17

// ======================================================
// Bit positions inside a used transmit slot
`define BIT_SY          0
`define BIT_CHG         1
`define BIT_PDOWN       2
`define BIT_ATTEN       3
`define BIT_LOOP        4
`define BIT_SYM_ZERO    5
`define BIT_SYM_SIGN    6
`define BIT_SYM_MAG     7

// Receive sampling point: slot bit 10 plus two synchroniser stages
`define LD_SAMPLE_BIT   5'h0C

// ======================================================
// Register map
`define ADDR_CTRL       6'h00
`define ADDR_STATUS     6'h01
`define CTRL_RESET      12'h249
`define ACT_HOLD        8'h04
`define RST_HOLD        6'h3F

`endif

//--- common/afe_tdm_pkg.sv
`default_nettype none

package afe_tdm_pkg;
  // Line symbol as handed in by the user side
  typedef enum logic [2:0] {Q_ZERO, Q_M3, Q_M1, Q_P3, Q_P1} quat_e;

  // Per-port analog controls
  typedef struct packed {
    logic loopback;
    logic atten;
    logic pdown;
  } ctrl_s;
endpackage

`default_nettype wire

//--- common/tdm_slot_if.sv
`default_nettype none

interface tdm_slot_if;
  logic [3:0][20:0] word;      // Slot contents per port
  logic             frame_end; // Last bit of the frame
  logic             ld_valid;  // Level-detect sample taken
  logic [1:0]       ld_port;   // Port of that sample
  logic             ld_bit;    // Sampled level

  modport framer (input word, output frame_end, ld_valid, ld_port, ld_bit);
  modport core   (output word, input frame_end, ld_valid, ld_port, ld_bit);
endinterface

`default_nettype wire

//--- rtl/afe_serial_tdm_interface.sv
// Operation
// R1: Flag 0 makes the front end keep its latched port controls.
// R2: With flag 0, the three control positions are sent as 0.
// R3: Any control change sends flag 1 with all three current values.
// R4: Power-down bit 1 powers the port down, 0 powers it up.
// R5: Attenuation bit 1 for short lines, 0 for long lines.
// R6: Loopback bit 1 closes the analog loop, 0 is normal operation.
// R7: Slot-sync bit is 1 on transmit, 0 on receive.
// R8: Every reserved bit is driven 0.
// R9: Symbols coded on three bits: zero flag, sign, magnitude.
// R10: Level-detect toggling means line activity; static means quiet.
// R11: Front end supplies the 15.36 MHz master clock.
// R12: Frame of 192 bits: eight 21-bit slots, one 24-bit sync slot.
// R13: Slots 1, 3, 5, 7 carry ports 0 to 3.
// R14: Receive slot carries level-detect bit in its last 20 bits.
// R15: Bit layout after slot-sync bit chosen by this design.
//
// The Wishbone register port and the address map were chosen for this implementation.
`default_nettype none
`include "afe_tdm_params.svh"

module afe_serial_tdm_interface
  import afe_tdm_pkg::*;
#(
  parameter logic [7:0] ACT_HOLD_FRAMES = `ACT_HOLD
) (
  input  wire logic        clk_i,                  // System clock 125 MHz
  input  wire logic        rst_i,                  // Synchronous reset
  input  wire logic [7:0]  wb_adr_i,               // Byte address
  input  wire logic [31:0] wb_dat_i,               // Write data
  output logic      [31:0] wb_dat_o,               // Read data
  input  wire logic [3:0]  wb_sel_i,               // Byte enables
  input  wire logic        wb_we_i,                // Write strobe
  input  wire logic        wb_cyc_i,               // Cycle
  input  wire logic        wb_stb_i,               // Strobe
  output logic             wb_ack_o,               // Acknowledge
  input  wire logic        master_clock_input_i,   // Link clock
  input  wire logic        afe_rx_serial_line_i,   // Receive line
  output logic             afe_tx_serial_line_o,   // Transmit line
  input  wire logic [11:0] tx_sym_i,               // Four symbols
  output logic             sym_taken_o,            // Symbols captured
  output logic [3:0]       line_active_o           // Activity per port
);

  // ======================================================
  // Parameter check
  if (ACT_HOLD_FRAMES == 8'h00) begin : g_chk
    $error("ACT_HOLD_FRAMES must be at least 1");
  end

  // Register decode, shared by read and write paths
  function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
    reg_hit = (adr[7:2] == idx) && (adr[1:0] == 2'h0);
  endfunction

  // Quaternary symbol to its three line bits {zero, sign, magnitude}
  function automatic logic [2:0] encode_sym(input quat_e q);
    case (q)
      Q_ZERO:  encode_sym = 3'h4; // Don't-care bits sent as 0
      Q_M3:    encode_sym = 3'h0;
      Q_M1:    encode_sym = 3'h1;
      Q_P3:    encode_sym = 3'h2;
      Q_P1:    encode_sym = 3'h3;
      default: encode_sym = 3'h4;
    endcase
  endfunction

  // ======================================================
  // System domain: register file
  logic [11:0] ctrl;          // Per port {loopback, atten, pdown}
  logic [3:0]  active_sync;
  logic        wb_req;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Single-cycle ack, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Control register; byte lanes 0 and 1 hold its 12 bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && reg_hit(wb_adr_i, `ADDR_CTRL)) begin // Lands with ack
      if (wb_sel_i[0]) begin
        ctrl[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl[11:8] <= wb_dat_i[11:8];
      end
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      if (reg_hit(wb_adr_i, `ADDR_CTRL)) begin
        wb_dat_o <= {20'h00000, ctrl};
      end else if (reg_hit(wb_adr_i, `ADDR_STATUS)) begin
        wb_dat_o <= {28'h0000000, active_sync};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ======================================================
  // System domain: reset stretched for the link clock
  logic [5:0] rst_hold;
  logic       link_rst_req;   // Registered, so the synchroniser sees no glitch

  // A reset of a few system cycles could fall between two link edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_hold     <= `RST_HOLD;
      link_rst_req <= 1'b1;
    end else if (rst_hold != 6'h00) begin
      rst_hold     <= rst_hold - 6'h01;
      link_rst_req <= 1'b1;
    end else begin
      link_rst_req <= 1'b0;
    end
  end

  // ======================================================
  // System domain: answer to the link's frame request
  logic        req_sync;
  logic        ack_tgl;
  logic [11:0] bundle_ctrl;   // Held stable while the link copies it
  logic [11:0] bundle_sym;

  // A new request toggle captures controls and symbols
  always_ff @(posedge clk_i) begin
    if (rst_i || link_rst_req) begin // Idle until the link side is reset
      ack_tgl     <= 1'b0;
      sym_taken_o <= 1'b0;
      bundle_ctrl <= `CTRL_RESET;
      bundle_sym  <= 12'h000;
    end else begin
      sym_taken_o <= 1'b0;
      if (req_sync != ack_tgl) begin
        ack_tgl     <= ~ack_tgl;
        sym_taken_o <= 1'b1;
        bundle_ctrl <= ctrl;
        bundle_sym  <= tx_sym_i;
      end
    end
  end

  // Activity levels from the link domain
  always_ff @(posedge clk_i) begin
    if (rst_i || link_rst_req) begin
      line_active_o <= 4'h0;
    end else begin
      line_active_o <= active_sync;
    end
  end

  // ======================================================
  // Link domain: reset, crossings and framer
  logic       link_rst;
  logic       rx_sync;
  logic       ack_sync;
  logic       req_tgl;
  logic [3:0] link_active;
  tdm_slot_if slot_bus ();

  // Stretched reset carried into the link clock
  bit_sync #(.W(1)) u_rst_sync (
    .clk_i (master_clock_input_i),
    .d_i   (link_rst_req),
    .q_o   (link_rst)
  );

  // Receive pin passes two flops before use
  bit_sync #(.W(1)) u_rx_sync (
    .clk_i (master_clock_input_i),
    .d_i   (afe_rx_serial_line_i),
    .q_o   (rx_sync)
  );

  bit_sync #(.W(1)) u_ack_sync (
    .clk_i (master_clock_input_i),
    .d_i   (ack_tgl),
    .q_o   (ack_sync)
  );

  bit_sync #(.W(1)) u_req_sync (
    .clk_i (clk_i),
    .d_i   (req_tgl),
    .q_o   (req_sync)
  );

  // Independent per-port levels, so a plain bit crossing suffices
  bit_sync #(.W(4)) u_act_sync (
    .clk_i (clk_i),
    .d_i   (link_active),
    .q_o   (active_sync)
  );

  tdm_framer u_framer (
    .link_clk_i (master_clock_input_i), // R11
    .link_rst_i (link_rst),
    .rx_sync_i  (rx_sync),
    .tx_o       (afe_tx_serial_line_o),
    .slot       (slot_bus.framer)
  );

  // ======================================================
  // Link domain: request new data once per frame
  logic        ack_seen;
  logic [11:0] stage_ctrl;
  logic [11:0] stage_sym;

  // Only one request outstanding; a slow answer reuses old data
  always_ff @(posedge master_clock_input_i) begin
    if (link_rst) begin
      req_tgl <= 1'b0;
    end else if (slot_bus.frame_end && (req_tgl == ack_sync)) begin
      req_tgl <= ~req_tgl;
    end
  end

  // Copy the bundle when its answer toggle arrives
  always_ff @(posedge master_clock_input_i) begin
    if (link_rst) begin
      ack_seen   <= 1'b0;
      stage_ctrl <= `CTRL_RESET;
      stage_sym  <= 12'h000;
    end else if (ack_sync != ack_seen) begin
      ack_seen   <= ack_sync;
      stage_ctrl <= bundle_ctrl;
      stage_sym  <= bundle_sym;
    end
  end

  // ======================================================
  // Link domain: per-port slot words and activity
  logic [3:0] sent_valid;
  logic [3:0] ld_last;

  for (genvar p = 0; p < 4; p++) begin : g_port
    ctrl_s      want;
    ctrl_s      sent;
    logic       chg;
    logic [7:0] act_cnt;

    assign want = ctrl_s'(stage_ctrl[3*p +: 3]);
    assign chg  = !sent_valid[p] || (want != sent); // R3

    // Slot word rebuilt only at frame end, so stable for a whole frame
    always_ff @(posedge master_clock_input_i) begin
      if (link_rst) begin
        slot_bus.word[p] <= 21'h000000;
        sent             <= ctrl_s'(3'h1);
        sent_valid[p]    <= 1'b0;
      end else if (slot_bus.frame_end) begin
        slot_bus.word[p]                <= 21'h000000;                  // R8
        slot_bus.word[p][`BIT_SY]       <= 1'b1;                        // R7
        slot_bus.word[p][`BIT_CHG]      <= chg;                         // R1 R3
        slot_bus.word[p][`BIT_PDOWN]    <= chg ? want.pdown : 1'b0;     // R2 R4
        slot_bus.word[p][`BIT_ATTEN]    <= chg ? want.atten : 1'b0;     // R2 R5
        slot_bus.word[p][`BIT_LOOP]     <= chg ? want.loopback : 1'b0;  // R2 R6
        slot_bus.word[p][`BIT_SYM_MAG:`BIT_SYM_ZERO] <=
          {<<{encode_sym(quat_e'(stage_sym[3*p +: 3]))}};                // R9 R15
        sent          <= want;
        sent_valid[p] <= 1'b1;
      end
    end

    // Toggling between frames restarts the hold count
    always_ff @(posedge master_clock_input_i) begin
      if (link_rst) begin
        ld_last[p] <= 1'b0;
        act_cnt    <= 8'h00;
      end else if (slot_bus.ld_valid && (slot_bus.ld_port == 2'(p))) begin
        ld_last[p] <= slot_bus.ld_bit;
        if (slot_bus.ld_bit != ld_last[p]) begin
          act_cnt <= ACT_HOLD_FRAMES; // R10
        end else if (act_cnt != 8'h00) begin
          act_cnt <= act_cnt - 8'h01;
        end
      end
    end

    // Registered activity flag for the crossing
    always_ff @(posedge master_clock_input_i) begin
      if (link_rst) begin
        link_active[p] <= 1'b0;
      end else begin
        link_active[p] <= (act_cnt != 8'h00); // R10
      end
    end
  end

endmodule

`default_nettype wire

//--- rtl/bit_sync.sv
`default_nettype none

module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i, // Destination clock
  input  wire logic [W-1:0] d_i,   // Foreign level
  output logic      [W-1:0] q_o    // Synchronised level
);
  logic [W-1:0] meta;

  // ======================================================
  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o  <= meta;
  end
endmodule

`default_nettype wire

//--- rtl/tdm_framer.sv
`default_nettype none
`include "afe_tdm_params.svh"

module tdm_framer (
  input  wire logic  link_clk_i, // Master clock from the front end
  input  wire logic  link_rst_i, // Reset, link domain
  input  wire logic  rx_sync_i,  // Receive line after synchroniser
  output logic       tx_o,       // Transmit line
  tdm_slot_if.framer slot        // Slot words and samples
);
  logic [3:0] slot_idx;
  logic [4:0] bit_idx;
  logic       last_bit;

  // Sync slot is longer than the data slots
  assign last_bit = (bit_idx == ((slot_idx == `LAST_SLOT) ? `SYNC_SLOT_LAST : `DATA_SLOT_LAST)); // R12

  // ======================================================
  // Slot and bit position counters
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      slot_idx <= 4'h0;
      bit_idx  <= 5'h00;
    end else if (last_bit) begin
      bit_idx  <= 5'h00;
      slot_idx <= (slot_idx == `LAST_SLOT) ? 4'h0 : slot_idx + 4'h1; // R12
    end else begin
      bit_idx  <= bit_idx + 5'h01;
    end
  end

  // Odd slots 1,3,5,7 carry ports 0..3; all else sends 0
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      tx_o <= 1'b0;
    end else begin
      tx_o <= slot_idx[0] ? slot.word[slot_idx[2:1]][bit_idx] : 1'b0; // R13 R8
    end
  end

  // ======================================================
  // Frame marker and level-detect sampling
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      slot.frame_end <= 1'b0;
      slot.ld_valid  <= 1'b0;
      slot.ld_port   <= 2'h0;
      slot.ld_bit    <= 1'b0;
    end else begin
      slot.frame_end <= (slot_idx == `LAST_SLOT) && last_bit;
      slot.ld_valid  <= slot_idx[0] && (bit_idx == `LD_SAMPLE_BIT); // R14
      slot.ld_port   <= slot_idx[2:1];
      slot.ld_bit    <= rx_sync_i;
    end
  end
endmodule

`default_nettype wire

//--- test/afe_link_model.sv
`default_nettype none
// ====
// Front end: master clock, slot decoder, level-detect sender
module afe_link_model (
  input  wire logic       rst_i,  // Reset
  input  wire logic       tx_i,   // Transmit line
  input  wire logic [3:0] act_i,  // Activity per port
  output logic            clk_o,  // Master clock
  output logic            rx_o,   // Receive line
  output logic [11:0]     ctrl_o, // Latched controls
  output logic [11:0]     sym_o   // Last symbol bits
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]       pos;
  logic             lock = 1'b0;
  logic [20:0]      sh;
  logic [3:0]       ld = 4'h0;
  wire logic [3:0]  slot = 4'(pos / 8'h15);
  wire logic [4:0]  sb   = 5'(pos % 8'h15);
  wire logic [1:0]  port = slot[2:1];
  wire logic        used = lock && slot[0] && !slot[3];
  wire logic [20:0] w    = {tx_i, sh[20:1]};
  // Free-running, phase unrelated to the system clock
  initial begin
    clk_o = 1'b0;
    #3.3;
    forever #40 clk_o = ~clk_o;
  end
  // Alignment from the first sync bit
  always @(posedge clk_o) begin
    sh <= w;
    if (rst_i || !lock) begin
      lock <= !rst_i && (tx_i === 1'b1);
      pos  <= 8'h16;
    end else begin
      pos <= (pos == 8'hBF) ? 8'h00 : pos + 8'h01;
    end
  end
  // A clear flag keeps the latch; level bit toggles per frame when active
  always @(posedge clk_o) begin
    if (used && sb == 5'h14 && w[1]) begin
      ctrl_o[3*port +: 3] <= w[4:2];
    end
    if (used && sb == 5'h14) begin
      sym_o[3*port +: 3] <= {w[5], w[6], w[7]};
    end
    if (pos == 8'h00) begin
      ld <= ld ^ act_i;
    end
    rx_o <= used && sb != 5'h00 && ld[port];
  end
endmodule
`default_nettype wire

//--- test/afe_serial_tdm_interface_bench.sv
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED at %0t: %0h vs %0h", $time, g, e); end end
module afe_serial_tdm_interface_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_ack_o;
  logic        lclk;
  logic        rx;
  logic        tx;
  logic [11:0] tx_sym_i = 12'h000;
  logic        sym_taken_o;
  logic [3:0]  line_active_o;
  logic [3:0]  act = 4'h0;
  logic [11:0] mctrl, msym, s, c, e;
  logic [3:0]  a;
  logic [31:0] q;
  logic [7:0]  bad [3] = '{8'h01, 8'h04, 8'h08};
  int          n_errors = 0;
  int          compares = 0;
  // ====
  // Rows: symbols, controls, expected symbol bits, activity
  logic [39:0] rows [4] = '{{12'h8D1, 12'h000, 12'h688, 4'hA}, {12'hDE8, 12'hFFF, 12'h924, 4'h5},
                            {12'h29C, 12'h5A3, 12'h053, 4'hF}, {12'h000, 12'h5A3, 12'h924, 4'h0}};

  afe_serial_tdm_interface #(.ACT_HOLD_FRAMES(8'h01)) dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .master_clock_input_i(lclk),
    .afe_rx_serial_line_i(rx), .afe_tx_serial_line_o(tx), .tx_sym_i, .sym_taken_o, .line_active_o);
  afe_link_model afe (.rst_i, .tx_i(tx), .act_i(act), .clk_o(lclk), .rx_o(rx), .ctrl_o(mctrl), .sym_o(msym));

  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One classic cycle; waits for ack, the watchdog bounds it
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] se);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    wb_sel_i <= se;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wait_frames(input int n);
    repeat (n) @(posedge clk_i iff sym_taken_o === 1'b1);
  endtask

  initial begin
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #800_000;
    n_errors++;
    test_done();
  end
  initial begin
    // Two cycles; the design stretches reset for the link side
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    `CHK(q, 32'h249)
    wait_frames(3);
    `CHK(mctrl, 12'h249)
    foreach (rows[i]) begin
      {s, c, e, a} = rows[i];
      wait_frames(1);
      tx_sym_i <= s;
      act      <= a;
      wb(1'b1, 8'h00, {20'h0, c}, 4'hF);
      wait_frames(6);
      `CHK(mctrl, c)
      `CHK(msym, e)
      `CHK(line_active_o, a)
      wb(1'b0, 8'h04, 32'h0, 4'hF);
      `CHK(q, {28'h0, a})
    end
    // Unaligned, read-only and unmapped places ignore writes
    foreach (bad[i]) begin
      wb(1'b1, bad[i], 32'hFFF, 4'hF);
      wb(1'b0, bad[i], 32'h0, 4'hF);
      `CHK(q, 32'h0)
    end
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    `CHK(q, 32'h5A3)
    // Upper lane only; all ports active again
    act <= 4'hF;
    wb(1'b1, 8'h00, 32'hFFF, 4'h2);
    wait_frames(3);
    `CHK(mctrl, 12'hFA3)
    `CHK(line_active_o, 4'hF)
    // Mid-run reset, long enough for model and checker to drop their alignment
    rst_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    `CHK(wb_ack_o, 1'b0)
    `CHK(sym_taken_o, 1'b0)
    `CHK(line_active_o, 4'h0)
    `CHK(wb_dat_o, 32'h0)
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    `CHK(q, 32'h249)
    wait_frames(3);
    `CHK(mctrl, 12'h249)
    test_done();
  end
endmodule
`default_nettype wire

//--- test/afe_tdm_asserts.sv
`default_nettype none
// ====
// Port checker: bus handshake, capture pacing, slot layout
module afe_tdm_asserts (
  input wire logic clk_i,                // System clock
  input wire logic rst_i,                // Reset
  input wire logic wb_cyc_i,             // Cycle
  input wire logic wb_stb_i,             // Strobe
  input wire logic wb_ack_o,             // Acknowledge
  input wire logic sym_taken_o,          // Capture pulse
  input wire logic master_clock_input_i, // Link clock
  input wire logic afe_tx_serial_line_o  // Transmit line
);
  logic [7:0]      pos;
  logic            lock;
  logic [11:0]     gap;
  logic            seen;
  wire logic [3:0] slot = 4'(pos / 8'h15);
  wire logic [4:0] sb   = 5'(pos % 8'h15);
  wire logic       used = lock && slot[0] && !slot[3];
  // Position from first sync bit; raw reset is fine, an unknown lock also restarts the search
  always_ff @(posedge master_clock_input_i) begin
    if (rst_i || lock !== 1'b1) begin
      lock <= !rst_i && (afe_tx_serial_line_o === 1'b1);
      pos  <= 8'h16;
    end else begin
      pos <= (pos == 8'hBF) ? 8'h00 : pos + 8'h01;
    end
  end
  // Cycles since last capture, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap  <= 12'h000;
      seen <= 1'b0;
    end else begin
      gap  <= sym_taken_o ? 12'h000 : gap + {11'h0, gap != 12'hFFF};
      seen <= seen || sym_taken_o;
    end
  end
  sequence s_ctrl_quiet;
    !afe_tx_serial_line_o [*3];
  endsequence
  sequence s_sym_quiet;
    !afe_tx_serial_line_o [*2];
  endsequence
  AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_SYM_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    sym_taken_o |=> !sym_taken_o) else $error("capture held");
  AST_SYM_FRAME: assert property (@(posedge clk_i) disable iff (rst_i)
    sym_taken_o && seen |-> gap > 12'h700) else $error("captures too close");
  AST_SYNC_ONE: assert property (@(posedge master_clock_input_i) disable iff (rst_i)
    used && sb == 5'h00 |-> afe_tx_serial_line_o) else $error("sync bit low");
  AST_UNUSED_ZERO: assert property (@(posedge master_clock_input_i) disable iff (rst_i)
    lock && !used |-> !afe_tx_serial_line_o) else $error("unused slot busy");
  AST_RESERVED_ZERO: assert property (@(posedge master_clock_input_i) disable iff (rst_i)
    used && sb > 5'h07 |-> !afe_tx_serial_line_o) else $error("reserved bit set");
  AST_FLAG_QUIET: assert property (@(posedge master_clock_input_i) disable iff (rst_i)
    used && sb == 5'h01 && !afe_tx_serial_line_o |=> s_ctrl_quiet) else $error("idle controls set");
  AST_ZERO_SYM: assert property (@(posedge master_clock_input_i) disable iff (rst_i)
    used && sb == 5'h05 && afe_tx_serial_line_o |=> s_sym_quiet) else $error("zero symbol bits set");
endmodule

bind afe_serial_tdm_interface afe_tdm_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .sym_taken_o, .master_clock_input_i, .afe_tx_serial_line_o);
`default_nettype wire
